// ---- emc_ctrl.sv ----
// Host-side controller that reads, programs, verifies and identifies the EPROM.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Controller drives all eight data bits at once while programming.
// - After setup, one 100 us low pulse on chip select writes a byte.
// - On mismatch pulse again, giving up after 25 pulses total.
// - Program-verify at each address right after each pulse; no final pass over all addresses.
// - Verify holds select and gate low; sample after verify delay.
// - Identify holds other address lines, select and gate low.
// - Select is per-device; gate is the common read strobe.
module emc_ctrl
    import emc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic       clk_en_i,
    // Request side
    input  wire logic       req_valid_i,
    output logic            req_ready_o,
    input  wire emc_req_t   req_i,
    // Answer side
    output logic            rsp_valid_o,
    output logic [7:0]      rsp_data_o,
    output logic            rsp_fail_o,
    // Device pins
    output logic [15:0]     address_lines_o,
    input  wire logic [7:0] data_lines_i,
    output logic [7:0]      data_lines_o,
    output logic            data_lines_oe_o,
    output logic            sel_n_o,
    output logic            gate_n_o,
    output logic            prog_supply_o,
    output logic            identify_high_voltage_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    emc_regs_t r_q;
    emc_regs_t r_d;

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Odd parity check over a whole identifier byte.
    function automatic logic odd_parity(input logic [7:0] b);
        odd_parity = ^b;
    endfunction

    function automatic emc_pins_t idle_pins();
        emc_pins_t p;
        p = '0;
        p.sel_n = 1'b1;
        p.gate_n = 1'b1;
        idle_pins = p;
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        r_d = r_q;
        r_d.done = 1'b0;
        case (r_q.state)
            EMC_IDLE: begin
                r_d.pins = idle_pins();
                if (req_valid_i) begin
                    r_d.req = req_i;
                    r_d.pulses = '0;
                    r_d.fail = 1'b0;
                    r_d.scan = '0;
                    r_d.cnt = SETUP_CYC;
                    r_d.state = EMC_SETUP;
                    r_d.pins.addr = req_i.addr;
                    case (req_i.cmd)
                        EMC_CMD_PROG: begin
                            r_d.pins.prog_supply = 1'b1;
                            r_d.pins.data = req_i.data;
                            r_d.pins.data_oe = 1'b1;
                        end
                        EMC_CMD_IDENT: begin
                            // Only the byte-select line may be high here.
                            r_d.pins.addr = '0;
                            r_d.pins.addr[ID_SEL_BIT] = req_i.addr[ID_SEL_BIT];
                            r_d.pins.ident_high = 1'b1;
                        end
                        EMC_CMD_CHECK: r_d.pins.addr = '0;
                        default: ;
                    endcase
                end
            end
            EMC_SETUP: begin
                if (r_q.cnt > 10'h001) begin
                    r_d.cnt = r_q.cnt - 10'h001;
                end else if (r_q.req.cmd == EMC_CMD_PROG) begin
                    r_d.pins.sel_n = 1'b0;
                    r_d.cnt = PROG_PULSE_CYC;
                    r_d.pulses = r_q.pulses + 5'h01;
                    r_d.state = EMC_PULSE;
                end else begin
                    r_d.pins.sel_n = 1'b0;
                    r_d.pins.gate_n = 1'b0;
                    r_d.cnt = ACCESS_CYC;
                    r_d.state = EMC_READ;
                end
            end
            EMC_PULSE: begin
                if (r_q.cnt > 10'h001) begin
                    r_d.cnt = r_q.cnt - 10'h001;
                end else begin
                    // Drop supply and release data before driving gate low.
                    r_d.pins.sel_n = 1'b1;
                    r_d.pins.prog_supply = 1'b0;
                    r_d.pins.data_oe = 1'b0;
                    r_d.cnt = SETUP_CYC;
                    r_d.state = EMC_VERIFY;
                end
            end
            EMC_VERIFY: begin
                // Select still high means the settle wait after the pulse is running.
                // Keying on select lets the settle and verify counts share a value.
                if (r_q.pins.sel_n) begin
                    if (r_q.cnt > 10'h001) begin
                        r_d.cnt = r_q.cnt - 10'h001;
                    end else begin
                        r_d.pins.sel_n = 1'b0;
                        r_d.pins.gate_n = 1'b0;
                        r_d.cnt = VERIFY_CYC;
                    end
                end else if (r_q.cnt > 10'h001) begin
                    r_d.cnt = r_q.cnt - 10'h001;
                end else begin
                    r_d.rdata = data_lines_i;
                    r_d.pins = idle_pins();
                    r_d.pins.addr = r_q.req.addr;
                    if (data_lines_i == r_q.req.data) begin
                        r_d.state = EMC_DONE;
                    end else if (r_q.pulses >= MAX_PULSES) begin
                        r_d.fail = 1'b1;
                        r_d.state = EMC_DONE;
                    end else begin
                        r_d.pins.prog_supply = 1'b1;
                        r_d.pins.data = r_q.req.data;
                        r_d.pins.data_oe = 1'b1;
                        r_d.cnt = SETUP_CYC;
                        r_d.state = EMC_SETUP;
                    end
                end
            end
            EMC_READ: begin
                if (r_q.cnt > 10'h001) begin
                    r_d.cnt = r_q.cnt - 10'h001;
                end else if (r_q.req.cmd == EMC_CMD_CHECK) begin
                    // Blank check: any cleared bit means the part is not erased.
                    if (data_lines_i != ERASED_BYTE) begin
                        r_d.fail = 1'b1;
                    end
                    if (r_q.scan == ADDR_LAST) begin
                        r_d.pins = idle_pins();
                        r_d.state = EMC_DONE;
                    end else begin
                        r_d.scan = r_q.scan + 16'h0001;
                        r_d.pins.addr = r_q.scan + 16'h0001;
                        r_d.cnt = ACCESS_CYC;
                    end
                end else begin
                    r_d.rdata = data_lines_i;
                    if (r_q.req.cmd == EMC_CMD_IDENT) begin
                        r_d.fail = ~odd_parity(data_lines_i);
                    end
                    r_d.pins = idle_pins();
                    r_d.state = EMC_DONE;
                end
            end
            EMC_DONE: begin
                r_d.done = 1'b1;
                r_d.state = EMC_IDLE;
            end
            default: r_d.state = EMC_IDLE;
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            r_q <= '0;
            r_q.state <= EMC_IDLE;
            r_q.pins.sel_n <= 1'b1;
            r_q.pins.gate_n <= 1'b1;
        end else if (clk_en_i) begin
            r_q <= r_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Ready follows the enable, so a frozen block never takes a request.
    assign req_ready_o = (r_q.state == EMC_IDLE) && clk_en_i;
    assign rsp_valid_o = r_q.done;
    assign rsp_data_o = r_q.rdata;
    assign rsp_fail_o = r_q.fail;
    assign address_lines_o = r_q.pins.addr;
    assign data_lines_o = r_q.pins.data;
    assign data_lines_oe_o = r_q.pins.data_oe;
    assign sel_n_o = r_q.pins.sel_n;
    assign gate_n_o = r_q.pins.gate_n;
    assign prog_supply_o = r_q.pins.prog_supply;
    assign identify_high_voltage_o = r_q.pins.ident_high;

endmodule
`default_nettype wire

// ---- emc_pkg.sv ----
// Package of constants and carrier types for the EPROM mode controller.
package emc_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam logic [15:0] ADDR_LAST = 16'hFFFF;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;
    localparam int unsigned ID_SEL_BIT = 0;
    localparam int unsigned ID_MODE_BIT = 9;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned PROG_PULSE_NS = 100000;
    localparam int unsigned ACCESS_DELAY_NS = 250;
    localparam int unsigned VERIFY_DELAY_NS = 250;
    localparam int unsigned SETUP_NS = 100;
    localparam logic [9:0] PROG_PULSE_CYC = 10'(PROG_PULSE_NS / CLK_PERIOD_NS);
    localparam logic [9:0] ACCESS_CYC =
        10'((ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] VERIFY_CYC =
        10'((VERIFY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] SETUP_CYC =
        10'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] MAX_PULSES = 5'h19;

    // ****************************************************************
    // Commands and states
    // ****************************************************************
    typedef enum logic [1:0] {
        EMC_CMD_READ = 2'b00,
        EMC_CMD_PROG = 2'b01,
        EMC_CMD_IDENT = 2'b10,
        EMC_CMD_CHECK = 2'b11
    } emc_cmd_t;

    typedef enum logic [2:0] {
        EMC_IDLE   = 3'b000,
        EMC_SETUP  = 3'b001,
        EMC_PULSE  = 3'b010,
        EMC_VERIFY = 3'b011,
        EMC_READ   = 3'b100,
        EMC_DONE   = 3'b101
    } emc_state_t;

    typedef struct packed {
        emc_cmd_t    cmd;
        logic [15:0] addr;
        logic [7:0]  data;
    } emc_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        data_oe;
        logic        sel_n;
        logic        gate_n;
        logic        prog_supply;
        logic        ident_high;
    } emc_pins_t;

    typedef struct packed {
        emc_state_t  state;
        emc_req_t    req;
        logic [9:0]  cnt;
        logic [4:0]  pulses;
        logic [15:0] scan;
        logic [7:0]  rdata;
        logic        fail;
        logic        done;
        emc_pins_t   pins;
    } emc_regs_t;

endpackage

// ---- emc_dev_model.sv ----
// Behavioural model of the byte-wide EPROM as seen from its pins.
`timescale 1ns/100ps
`default_nettype none
module emc_dev_model #(
    parameter logic [7:0] MAKER_ID = 8'h01, // Arbitrary code with odd parity.
    parameter logic [7:0] PART_ID  = 8'h07  // Arbitrary code with odd parity.
) (
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  din_i,
    input  wire logic        sel_n_i,
    input  wire logic        gate_n_i,
    input  wire logic        prog_i,
    input  wire logic        idhv_i,
    output logic      [7:0]  dout_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] rd_w;
    logic [7:0] last_q;
    logic       drv_w;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        last_q = 8'h00;
    end
    assign rd_w = idhv_i ? (addr_i[0] ? PART_ID : MAKER_ID) : mem[addr_i];
    assign drv_w = !sel_n_i && !gate_n_i && !prog_i;
    // A released bus shows the inverse of its last value, so stale data never matches.
    assign dout_o = drv_w ? rd_w : ~last_q;
    always @(drv_w or rd_w) if (drv_w) last_q = rd_w;
    always @(negedge sel_n_i)
        if (prog_i) mem[addr_i] = mem[addr_i] & din_i;
endmodule
`default_nettype wire

// ---- emc_ctrl_sva.sv ----
// Checker of the controller's pin sequencing.
`timescale 1ns/100ps
`default_nettype none
module emc_ctrl_sva
    import emc_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        resetn_i,
    input wire logic        rsp_valid_o,
    input wire logic        rsp_fail_o,
    input wire logic [15:0] address_lines_o,
    input wire logic [7:0]  data_lines_o,
    input wire logic        data_lines_oe_o,
    input wire logic        sel_n_o,
    input wire logic        gate_n_o,
    input wire logic        prog_supply_o,
    input wire logic        identify_high_voltage_o
);
    logic [10:0] lo_q;
    logic [5:0]  npul_q;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // Pulses are counted per operation, so the limit applies to one location.
    always_ff @(posedge clk_sys_i) begin
        lo_q <= (!sel_n_o && prog_supply_o) ? lo_q + 11'h001 : 11'h000;
        if (!resetn_i || rsp_valid_o)
            npul_q <= 6'h00;
        else if (!sel_n_o && prog_supply_o && lo_q == 11'h000)
            npul_q <= npul_q + 6'h01;
    end
    a_pulse_width: assert property (
        $rose(sel_n_o) && $past(prog_supply_o) |-> lo_q == 11'(PROG_PULSE_CYC))
        else $error("program pulse length wrong");
    a_setup_first: assert property (
        $fell(sel_n_o) && prog_supply_o |-> $past(prog_supply_o)
        && $stable(address_lines_o) && $stable(data_lines_o) && data_lines_oe_o)
        else $error("pulse began before lines settled");
    a_hold_pulse: assert property (
        !sel_n_o && prog_supply_o && !$past(sel_n_o)
        |-> $stable(address_lines_o) && $stable(data_lines_o) && data_lines_oe_o)
        else $error("lines moved during pulse");
    a_oe_prog: assert property (data_lines_oe_o |-> prog_supply_o)
        else $error("data driven outside programming");
    a_verify_follows: assert property (
        $rose(sel_n_o) && $past(prog_supply_o)
        |=> !sel_n_o && !gate_n_o && !prog_supply_o)
        else $error("verify did not follow pulse");
    a_read_hold: assert property (
        $fell(gate_n_o) && !prog_supply_o
        |-> (!sel_n_o && !gate_n_o) [*3])
        else $error("read strobes released early");
    a_ident_lines: assert property (
        identify_high_voltage_o |-> !prog_supply_o
        && address_lines_o[15:10] == 6'h00 && address_lines_o[8:1] == 8'h00)
        else $error("identify address lines not low");
    a_fail_limit: assert property (
        rsp_valid_o && rsp_fail_o && npul_q != 6'h00
        |-> npul_q == 6'(MAX_PULSES))
        else $error("program gave up at wrong pulse count");
    cover property ($rose(sel_n_o) && $past(prog_supply_o));
    cover property (rsp_valid_o && rsp_fail_o);
    cover property (identify_high_voltage_o && !gate_n_o);
endmodule
bind emc_ctrl emc_ctrl_sva chk (.clk_sys_i, .resetn_i, .rsp_valid_o, .rsp_fail_o,
    .address_lines_o, .data_lines_o, .data_lines_oe_o, .sel_n_o, .gate_n_o, .prog_supply_o,
    .identify_high_voltage_o);
`default_nettype wire

// ---- test_eprom_mode_control.sv ----
// Self-checking bench for the EPROM mode controller against a device model.
`timescale 1ns/100ps
`default_nettype none
module test_eprom_mode_control;
    import emc_pkg::*;
    localparam logic [7:0] MAKER_ID = 8'h83; // Arbitrary code with odd parity.
    localparam logic [7:0] PART_ID  = 8'h8F; // Arbitrary code with odd parity.
    logic        clk_sys_i, resetn_i, req_valid_i, req_ready_o, rsp_valid_o, rsp_fail_o;
    logic        data_lines_oe_o, sel_n_o, gate_n_o, prog_supply_o, identify_high_voltage_o;
    logic [7:0]  rsp_data_o, data_lines_o, dev_w, bus_w, rd;
    logic [15:0] address_lines_o;
    emc_req_t    req_i;
    logic        rf;
    logic        clk_en_i, hung;
    int          error_cnt, checks_done;
    assign bus_w = data_lines_oe_o ? data_lines_o : dev_w;
    emc_ctrl dut (.clk_sys_i, .resetn_i, .clk_en_i, .req_valid_i, .req_ready_o, .req_i,
        .rsp_valid_o, .rsp_data_o, .rsp_fail_o, .address_lines_o, .data_lines_i(bus_w),
        .data_lines_o, .data_lines_oe_o, .sel_n_o, .gate_n_o, .prog_supply_o,
        .identify_high_voltage_o);
    emc_dev_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) dev (.addr_i(address_lines_o),
        .din_i(bus_w), .sel_n_i(sel_n_o), .gate_n_i(gate_n_o), .prog_i(prog_supply_o),
        .idhv_i(identify_high_voltage_o), .dout_o(dev_w));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // After a timeout every later operation is skipped, so the run reaches the verdict quickly.
    task automatic op(input emc_cmd_t c, input logic [15:0] a, input logic [7:0] d);
        int n;
        if (!hung) begin
            @(negedge clk_sys_i);
            req_i = '{cmd: c, addr: a, data: d};
            req_valid_i = 1'b1;
            for (n = 0; n < 40 && req_ready_o !== 1'b1; n++) @(negedge clk_sys_i);
            @(negedge clk_sys_i);
            req_valid_i = 1'b0;
            for (n = 0; n < 30000 && rsp_valid_o !== 1'b1; n++) @(negedge clk_sys_i);
            if (rsp_valid_o !== 1'b1) begin
                error_cnt++;
                hung = 1'b1;
            end
            rd = rsp_data_o;
            rf = rsp_fail_o;
        end
    endtask
    task automatic t_read_erased();
        op(EMC_CMD_READ, 16'h1234, 8'h00);
        chk(rd, ERASED_BYTE);
        chk({7'h00, rf}, 8'h00);
    endtask
    task automatic t_program();
        op(EMC_CMD_PROG, ADDR_LAST, 8'hA5);
        chk({7'h00, rf}, 8'h00);
        chk(rd, 8'hA5);
        op(EMC_CMD_READ, ADDR_LAST, 8'h00);
        chk(rd, 8'hA5);
    endtask
    // Bits already cleared cannot return to one, so this byte never verifies.
    task automatic t_give_up();
        op(EMC_CMD_PROG, ADDR_LAST, 8'h5A);
        chk({7'h00, rf}, 8'h01);
        op(EMC_CMD_READ, ADDR_LAST, 8'h00);
        chk(rd, 8'h00);
    endtask
    // A request made while the enable is low must wait, with the device left in standby.
    task automatic t_freeze();
        clk_en_i = 1'b0;
        fork
            op(EMC_CMD_READ, 16'h1234, 8'h00);
            begin
                repeat (3) @(negedge clk_sys_i);
                chk({5'h00, req_ready_o, sel_n_o, gate_n_o}, 8'h03);
                clk_en_i = 1'b1;
            end
        join
        chk(rd, ERASED_BYTE);
    endtask
    task automatic t_identify();
        op(EMC_CMD_IDENT, 16'hFFFE, 8'h00);
        chk(rd, MAKER_ID);
        chk({7'h00, ^rd}, 8'h01);
        op(EMC_CMD_IDENT, 16'h0001, 8'h00);
        chk(rd, PART_ID);
        chk({7'h00, rf}, 8'h00);
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        resetn_i = 1'b0;
        clk_en_i = 1'b1;
        hung = 1'b0;
        req_valid_i = 1'b0;
        req_i = '0;
        error_cnt = 0;
        checks_done = 0;
        repeat (5) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        t_read_erased();
        t_program();
        t_give_up();
        t_freeze();
        t_identify();
        give_verdict();
    end
endmodule
`default_nettype wire
